// file: design/ssw_defines.svh
// Timing constants for the supply supervisor and watchdog
`ifndef SSW_DEFINES_SVH
`define SSW_DEFINES_SVH
`define SSW_CLK_HZ 125000000
`define SSW_WDOG_TIMEOUT_MS 1600
`define SSW_RELEASE_MS 200
`define SSW_DEBOUNCE_MS 10
`define SSW_WDOG_CYCLES ((`SSW_CLK_HZ / 1000) * `SSW_WDOG_TIMEOUT_MS)
`define SSW_RELEASE_CYCLES ((`SSW_CLK_HZ / 1000) * `SSW_RELEASE_MS)
`define SSW_DEBOUNCE_CYCLES ((`SSW_CLK_HZ / 1000) * `SSW_DEBOUNCE_MS)
`define SSW_CNT_W 28
`endif

// file: design/ssw_pkg.sv
// Types shared by the supply supervisor and watchdog
package ssw_pkg;
  typedef enum logic [1:0] {
    SSW_RUN,
    SSW_HOLD,
    SSW_RELEASE
  } ssw_state_t;
  typedef struct packed {
    logic reset_pin_oe_n;
    logic reset_high;
  } ssw_rst_out_t;
endpackage

// file: design/ssw_supervisor.sv
// Supply supervisor, manual reset, watchdog and memory write gate
// What this block does
// [RULE1] Watchdog timeout drives resets active
// [RULE2] Host toggles kick within every timeout
// [RULE3] Watchdog source: data line or kick pin
// [RULE4] Supply fault asserts both resets
// [RULE5] Hold resets for release timeout after fault
// [RULE6] Manual reset low starts reset
// [RULE7] Manual reset input is debounced
// [RULE8] Reset held while low, then timeout
// [RULE9] External low on reset pin restarts reset
// [RULE10] Open-drain low reset plus high reset
// [RULE11] Write-protect high blocks memory writes
// [RULE12] Writes inhibited while supply below threshold
// [RULE13] Watchdog restarts when reset ends
// [RULE14] Timeouts are cycle-count parameters
`include "ssw_defines.svh"
module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter bit KICK_PIN_VARIANT = 1'b0,
  // [RULE14] cycle counts
  parameter logic [`SSW_CNT_W-1:0] WDOG_CYCLES = `SSW_CNT_W'(`SSW_WDOG_CYCLES),
  parameter logic [`SSW_CNT_W-1:0] RELEASE_CYCLES = `SSW_CNT_W'(`SSW_RELEASE_CYCLES),
  parameter logic [`SSW_CNT_W-1:0] DEBOUNCE_CYCLES = `SSW_CNT_W'(`SSW_DEBOUNCE_CYCLES)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic supply_fault,
  input wire logic manual_reset_in,
  input wire logic watchdog_kick_in,
  input wire logic serial_data_in,
  input wire logic reset_pin_in,
  input wire logic write_protect,
  input wire logic mem_write_req,
  output logic reset_pin_oe_n,
  output logic reset_pin_out,
  output logic reset_high,
  output logic mem_write_allow
);
  localparam int W = `SSW_CNT_W;

  logic [2:0] sync1_q, sync2_q;
  logic kick_prev_q, kick_prev_d;
  logic mr_stable_q, mr_stable_d;
  logic [W-1:0] deb_cnt_q, deb_cnt_d;
  logic [W-1:0] wd_cnt_q, wd_cnt_d;
  logic [W-1:0] rel_cnt_q, rel_cnt_d;
  ssw_state_t state_q, state_d;
  ssw_rst_out_t out_q, out_d;
  logic wp_q, wp_d;
  logic kick_s, mr_s, pin_s, wd_src, cause, wd_expire;
  logic [1:0] rel_hist_q, rel_hist_d;
  logic pin_armed;

  function automatic logic [W-1:0] cnt_inc(input logic [W-1:0] v);
    return v + W'(1);
  endfunction

  // Pins come from outside the clock domain
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
    end else begin
      sync1_q <= {reset_pin_in, manual_reset_in, KICK_PIN_VARIANT ? watchdog_kick_in : serial_data_in};
      sync2_q <= sync1_q;
    end
  end
  // [RULE3] kick source select
  assign wd_src = sync2_q[0];
  assign mr_s = sync2_q[1];
  assign pin_s = sync2_q[2];
  assign kick_s = wd_src ^ kick_prev_q;

  always_comb begin
    kick_prev_d = wd_src;
    mr_stable_d = mr_stable_q;
    deb_cnt_d = W'(0);
    // [RULE7] debounce manual input
    if (mr_s != mr_stable_q) begin
      deb_cnt_d = cnt_inc(deb_cnt_q);
      if (deb_cnt_q >= DEBOUNCE_CYCLES - W'(1)) begin
        mr_stable_d = mr_s;
        deb_cnt_d = W'(0);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      kick_prev_q <= 1'b1;
      mr_stable_q <= 1'b1;
      deb_cnt_q <= '0;
    end else begin
      kick_prev_q <= kick_prev_d;
      mr_stable_q <= mr_stable_d;
      deb_cnt_q <= deb_cnt_d;
    end
  end

  // Own drive on the pin reads back low, so only count it while released
  // Readback lags the pin by the sync depth, so blank it just after release
  assign pin_armed = &rel_hist_q;
  // [RULE4] [RULE6] [RULE9] reset causes
  assign cause = supply_fault || !mr_stable_q || (state_q == SSW_RUN && pin_armed && !pin_s);
  assign wd_expire = (wd_cnt_q >= WDOG_CYCLES - W'(1));

  always_comb begin
    rel_hist_d = {rel_hist_q[0], out_q.reset_pin_oe_n};
    state_d = state_q;
    wd_cnt_d = wd_cnt_q;
    rel_cnt_d = rel_cnt_q;
    unique case (state_q)
      SSW_RUN: begin
        // [RULE1] watchdog timeout
        wd_cnt_d = kick_s ? W'(0) : cnt_inc(wd_cnt_q);
        if (cause || wd_expire) begin
          state_d = SSW_HOLD;
        end
      end
      SSW_HOLD: begin
        // [RULE8] hold while cause stands
        rel_cnt_d = W'(0);
        if (!cause) begin
          state_d = SSW_RELEASE;
        end
      end
      SSW_RELEASE: begin
        // [RULE5] release timeout
        rel_cnt_d = cnt_inc(rel_cnt_q);
        if (cause) begin
          state_d = SSW_HOLD;
        end else if (rel_cnt_q >= RELEASE_CYCLES - W'(1)) begin
          state_d = SSW_RUN;
          // [RULE13] fresh watchdog period
          wd_cnt_d = W'(0);
        end
      end
      default: begin
        state_d = SSW_HOLD;
      end
    endcase
    // [RULE10] complementary outputs
    out_d.reset_pin_oe_n = (state_d == SSW_RUN);
    out_d.reset_high = (state_d != SSW_RUN);
    // [RULE11] [RULE12] write gate
    wp_d = mem_write_req && !write_protect && !supply_fault;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= SSW_HOLD;
      wd_cnt_q <= '0;
      rel_cnt_q <= '0;
      out_q <= '{reset_pin_oe_n: 1'b0, reset_high: 1'b1};
      wp_q <= 1'b0;
      rel_hist_q <= 2'h0;
    end else begin
      state_q <= state_d;
      wd_cnt_q <= wd_cnt_d;
      rel_cnt_q <= rel_cnt_d;
      out_q <= out_d;
      wp_q <= wp_d;
      rel_hist_q <= rel_hist_d;
    end
  end

  assign reset_pin_oe_n = out_q.reset_pin_oe_n;
  assign reset_pin_out = 1'b0;
  assign reset_high = out_q.reset_high;
  assign mem_write_allow = wp_q;

  // [RULE4] fault forces reset
  a_fault_resets: assert property (@(posedge clock) disable iff (!rst_n)
    supply_fault |-> ##1 reset_high) else $error("reset not active during supply fault");
  // [RULE5] release starts from zero count
  a_release_len: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == SSW_HOLD && state_d == SSW_RELEASE) |-> ##1 (reset_high && rel_cnt_q == W'(0)))
    else $error("release did not start from zero");
  // [RULE10] outputs complementary
  a_outs_compl: assert property (@(posedge clock) disable iff (!rst_n)
    reset_high == !reset_pin_oe_n) else $error("reset outputs disagree");
  // [RULE11] write protect blocks
  a_wp_blocks: assert property (@(posedge clock) disable iff (!rst_n)
    write_protect |=> !mem_write_allow) else $error("write allowed under protect");
  // [RULE12] fault blocks writes
  a_fault_blocks: assert property (@(posedge clock) disable iff (!rst_n)
    supply_fault |=> !mem_write_allow) else $error("write allowed under fault");
  // [RULE1] expiry starts reset
  a_wdog_expire: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == SSW_RUN && wd_expire) |=> (state_q == SSW_HOLD)) else $error("watchdog expiry ignored");
  // [RULE8] manual low holds reset
  a_mr_holds: assert property (@(posedge clock) disable iff (!rst_n)
    !mr_stable_q |=> (state_q == SSW_HOLD)) else $error("manual reset not held");
  // [RULE13] watchdog restarts
  a_wd_restart: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == SSW_RELEASE && state_d == SSW_RUN) |=> (wd_cnt_q == W'(0))) else $error("watchdog not restarted");
  // [RULE7] debounce holds stable value
  a_deb_stable: assert property (@(posedge clock) disable iff (!rst_n)
    (mr_s == mr_stable_q) |=> $stable(mr_stable_q)) else $error("debounced value moved");
  // [RULE9] external low starts reset
  a_pin_forces: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == SSW_RUN && pin_armed && !pin_s) |=> (state_q == SSW_HOLD)) else $error("pin reset ignored");
  // [RULE10] own drive not read back
  a_readback_blank: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == SSW_RUN && !pin_armed && !supply_fault && mr_stable_q && !wd_expire) |=> (state_q == SSW_RUN))
    else $error("stale pin level restarted reset");
  // [RULE5] release ends at full count
  a_release_full: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == SSW_RELEASE && state_d == SSW_RUN) |-> (rel_cnt_q == RELEASE_CYCLES - W'(1)))
    else $error("release ended early");
  // [RULE1] kick restarts watchdog
  a_kick_restart: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == SSW_RUN && kick_s) |=> (wd_cnt_q == W'(0))) else $error("kick did not restart watchdog");
  // [RULE11] clean request is allowed
  a_allow_follows: assert property (@(posedge clock) disable iff (!rst_n)
    (mem_write_req && !write_protect && !supply_fault) |=> mem_write_allow) else $error("clean write refused");

  c_wdog_trip: cover property (@(posedge clock) disable iff (!rst_n) state_q == SSW_RUN && wd_expire);
  c_release_done: cover property (@(posedge clock) disable iff (!rst_n)
    state_q == SSW_RELEASE && state_d == SSW_RUN);
  c_manual: cover property (@(posedge clock) disable iff (!rst_n) $fell(mr_stable_q));
  c_pin_forced: cover property (@(posedge clock) disable iff (!rst_n)
    state_q == SSW_RUN && pin_armed && !pin_s);
  c_kick_seen: cover property (@(posedge clock) disable iff (!rst_n)
    state_q == SSW_RUN && kick_s);
endmodule

// file: tb/ssw_host_model.sv
// Host model: kicks the watchdog line and resolves the reset pin
module ssw_host_model (
  input wire logic clock,
  input wire logic kick_en,
  input wire logic pull_low,
  input wire logic reset_pin_oe_n,
  output logic kick_line,
  output logic reset_pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  initial kick_line = 1'b0;
  always @(posedge clock) begin
    cnt_q <= cnt_q + 4'h1;
    if (kick_en && cnt_q == 4'hf) kick_line <= #1 ~kick_line;
  end
  // Pull-up wins unless someone pulls low
  assign reset_pin_level = (reset_pin_oe_n && !pull_low) ? 1'b1 : 1'b0;
endmodule

// file: tb/ssw_supervisor_tb.sv
// Self-checking bench for the supply supervisor
module ssw_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic fault = 1'b0;
  logic mr = 1'b1;
  logic pull = 1'b0;
  logic kick_en = 1'b1;
  logic wp = 1'b0;
  logic req = 1'b0;
  logic kick, pin, oe_n, rh, allow;
  logic oe2_n, rh2, rh2_hi;
  int bad_count = 0;
  int cmp_count = 0;
  // Rows: req, wp, fault, expected allow
  logic [3:0] rows [4] = '{4'h9, 4'hc, 4'ha, 4'h0};
  initial forever #4 clock = ~clock;
  ssw_supervisor #(.KICK_PIN_VARIANT(1'b0), .WDOG_CYCLES(28'h28), .RELEASE_CYCLES(28'h14),
    .DEBOUNCE_CYCLES(28'h4)) i_ssw_supervisor (.clock(clock), .rst_n(rst_n), .supply_fault(fault),
    .manual_reset_in(mr), .watchdog_kick_in(kick), .serial_data_in(kick), .reset_pin_in(pin),
    .write_protect(wp), .mem_write_req(req), .reset_pin_oe_n(oe_n), .reset_pin_out(),
    .reset_high(rh), .mem_write_allow(allow));
  ssw_host_model i_ssw_host_model (.clock(clock), .kick_en(kick_en), .pull_low(pull),
    .reset_pin_oe_n(oe_n), .kick_line(kick), .reset_pin_level(pin));
  // Kick-pin variant: serial line held idle, its own pin only pulled up
  ssw_supervisor #(.KICK_PIN_VARIANT(1'b1), .WDOG_CYCLES(28'h28), .RELEASE_CYCLES(28'h14),
    .DEBOUNCE_CYCLES(28'h4)) i_ssw_supervisor_kp (.clock(clock), .rst_n(rst_n), .supply_fault(fault),
    .manual_reset_in(mr), .watchdog_kick_in(kick), .serial_data_in(1'b1), .reset_pin_in(oe2_n),
    .write_protect(wp), .mem_write_req(req), .reset_pin_oe_n(oe2_n), .reset_pin_out(),
    .reset_high(rh2), .mem_write_allow());
  task automatic chk(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Bounded wait so a stuck reset is reported, not hung on
  task automatic wait_low(input int lim);
    int k;
    k = 0;
    while (rh !== 1'b0 && k < lim) begin
      cyc(1);
      k++;
    end
    chk("reset release", 1'b0, rh);
    chk("pin released", 1'b1, oe_n);
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #40000;
    bad_count++;
    wrap_up();
  end
  initial begin
    cyc(5);
    rst_n = 1'b1;
    chk("power-up hold", 1'b1, rh);
    cyc(15);
    chk("early release", 1'b1, rh);
    wait_low(10);
    foreach (rows[i]) begin
      {req, wp, fault} = rows[i][3:1];
      cyc(1);
      chk("write allow", rows[i][0], allow);
    end
    wait_low(30);
    fault = 1'b1;
    cyc(2);
    chk("fault reset", 1'b1, rh);
    chk("pin driven", 1'b0, oe_n);
    fault = 1'b0;
    cyc(17);
    chk("fault hold", 1'b1, rh);
    wait_low(8);
    // Bounce shorter than the debounce span must be ignored
    repeat (3) begin
      mr = 1'b0;
      cyc(2);
      mr = 1'b1;
      cyc(2);
    end
    chk("bounce", 1'b0, rh);
    mr = 1'b0;
    cyc(10);
    chk("manual reset", 1'b1, rh);
    cyc(30);
    mr = 1'b1;
    cyc(20);
    chk("manual hold", 1'b1, rh);
    wait_low(15);
    kick_en = 1'b0;
    pull = 1'b1;
    cyc(6);
    pull = 1'b0;
    cyc(3);
    chk("pin reset", 1'b1, rh);
    wait_low(30);
    cyc(36);
    chk("full period", 1'b0, rh);
    chk("kick pin bite", 1'b1, rh2);
    cyc(8);
    chk("watchdog bite", 1'b1, rh);
    kick_en = 1'b1;
    wait_low(30);
    rh2_hi = 1'b0;
    repeat (100) begin
      cyc(1);
      rh2_hi = rh2_hi | rh2;
    end
    chk("kicked alive", 1'b0, rh);
    chk("kick pin alive", 1'b0, rh2_hi);
    wrap_up();
  end
endmodule
